// ==== hdl/lds_pkg.sv ====
package lds_pkg;
  // Fixed upper five bits of the slave address
  localparam logic [4:0] ADDR_HI     = 5'h0F;
  // Control byte field positions
  localparam int         CO_BIT      = 7;
  localparam int         DC_BIT      = 6;
  // Bit slots per byte: 8 data plus acknowledge
  localparam logic [3:0] LAST_DBIT   = 4'h7;
  localparam logic [3:0] ACK_SLOT    = 4'h8;
  // Interface ready time after reset release
  localparam int         READY_NS    = 3000;
  localparam int         CLK_NS      = 10;
  localparam int         READY_CYC   = READY_NS / CLK_NS;
  localparam logic [8:0] READY_LAST  = 9'(READY_CYC - 1);
  // Synchroniser lanes
  localparam int         SY_SCL      = 0;
  localparam int         SY_SDA      = 1;
  localparam int         SY_SA0      = 2;
  localparam int         SY_SA1      = 3;
  localparam int         SY_TGL      = 4;
  localparam int         SY_W        = 5;
  typedef enum logic [2:0] {
    LDS_IDLE, LDS_ADDR, LDS_CTRL, LDS_DATA, LDS_READ, LDS_SKIP
  } lds_state_t;
endpackage : lds_pkg

// ==== hdl/lds_i2c_slave.sv ====
// Contract
// - Answer only slave addresses 0111100 to 0111111.
// - Two low address bits come from the two address-select pins.
// - Acknowledge a matching address; ignore the rest of a mismatched transfer.
// - In a write, first byte after address is a control byte steering routing.
// - In a read, shift data right after address acknowledge until master NACKs.
// - Read data leaves on separate open-drain serial_data_out pin.
// - continuation_flag 0: all later bytes are data until STOP or repeated START.
// - continuation_flag 1: one data byte, then a new control byte.
// - Write data with data_command_select 0 goes to the instruction decoder.
// - Read with data_command_select 0 returns the selected status register.
// - Write data with data_command_select 1 is stored to display RAM.
// - Read with data_command_select 1 returns no RAM contents.
// - Interface operational within 3 us after reset ends.
// - Status byte is the latest temperature measurement result.
// - Acknowledge a matching address and every written byte by pulling data low in the ninth clock.
// - continuation_flag is bit DB7, data_command_select is bit DB6.
`timescale 1ns/1ps
`default_nettype none
module lds_i2c_slave
  import lds_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda,
  output logic            o_sda_oe_b,
  output logic            o_sdo,
  output logic            o_sdo_oe_b,
  input  wire logic       i_addr_sel0,
  input  wire logic       i_addr_sel1,
  input  wire logic [7:0] i_temp_status,
  output logic            o_ready,
  output logic            o_cmd_valid,
  output logic [7:0]      o_cmd_byte,
  output logic            o_ram_wr,
  output logic [7:0]      o_ram_data,
  output logic            o_dc_mode
);

  // Link domain: bits shifted on rising SCL
  logic [3:0] lk_cnt_ff;
  logic [7:0] lk_sh_ff;
  logic [7:0] lk_byte_ff;
  logic       lk_tgl_ff;
  logic       lk_clr_ff;
  wire        lk_rst_b = i_rst_b & ~lk_clr_ff;
  wire        lk_last  = (lk_cnt_ff == LAST_DBIT);

  always_ff @(posedge i_scl or negedge lk_rst_b)
  begin
    if (!lk_rst_b)
    begin
      lk_cnt_ff <= 4'h0;
      lk_sh_ff  <= 8'h00;
    end
    else
    begin
      lk_cnt_ff <= (lk_cnt_ff == ACK_SLOT) ? 4'h0 : lk_cnt_ff + 4'h1;
      lk_sh_ff  <= (lk_cnt_ff == ACK_SLOT) ? lk_sh_ff : {lk_sh_ff[6:0], i_sda};
    end
  end

  // Byte word is held for a full byte time, so a toggle announces it
  always_ff @(posedge i_scl or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      lk_byte_ff <= 8'h00;
      lk_tgl_ff  <= 1'b0;
    end
    else if (lk_last)
    begin
      lk_byte_ff <= {lk_sh_ff[6:0], i_sda};
      lk_tgl_ff  <= ~lk_tgl_ff;
    end
  end

  // Three-stage synchronisers with agreement filter
  logic [SY_W-1:0] sy1_ff, sy2_ff, sy3_ff, flt_ff, flt_d_ff;
  wire  [SY_W-1:0] sy_in = {lk_tgl_ff, i_addr_sel1, i_addr_sel0, i_sda, i_scl};
  wire  [SY_W-1:0] agree = ~(sy2_ff ^ sy3_ff);
  wire  [SY_W-1:0] nxt_flt = (flt_ff & ~agree) | (sy3_ff & agree);

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      sy1_ff   <= 5'h03;
      sy2_ff   <= 5'h03;
      sy3_ff   <= 5'h03;
      flt_ff   <= 5'h03;
      flt_d_ff <= 5'h03;
    end
    else
    begin
      sy1_ff   <= sy_in;
      sy2_ff   <= sy1_ff;
      sy3_ff   <= sy2_ff;
      flt_ff   <= nxt_flt;
      flt_d_ff <= flt_ff;
    end
  end

  wire scl_h    = flt_ff[SY_SCL];
  wire scl_rise = scl_h & ~flt_d_ff[SY_SCL];
  wire scl_fall = ~scl_h & flt_d_ff[SY_SCL];
  wire sda_h    = flt_ff[SY_SDA];
  wire start_ev = scl_h & flt_d_ff[SY_SCL] & ~sda_h & flt_d_ff[SY_SDA];
  wire stop_ev  = scl_h & flt_d_ff[SY_SCL] & sda_h & ~flt_d_ff[SY_SDA];
  wire byte_ev  = flt_ff[SY_TGL] ^ flt_d_ff[SY_TGL];

  // Ready timer
  logic [8:0] rdy_cnt_ff;
  logic       ready_ff;
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rdy_cnt_ff <= 9'h000;
      ready_ff   <= 1'b0;
    end
    else if (!ready_ff)
    begin
      rdy_cnt_ff <= rdy_cnt_ff + 9'h001;
      ready_ff   <= (rdy_cnt_ff == READY_LAST);
    end
  end

  // Link counter held clear from START/STOP until SCL goes low
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      lk_clr_ff <= 1'b1;
    else if (start_ev | stop_ev)
      lk_clr_ff <= 1'b1;
    else if (!scl_h)
      lk_clr_ff <= 1'b0;
  end

  // Protocol engine
  lds_state_t st_ff, nxt_st;
  logic [3:0] bcnt_ff;
  logic [7:0] rx_ff, tx_ff;
  logic       rw_ff, co_ff, dc_ff, ack_ff, nack_ff, cmd_ff, ram_ff;
  logic [7:0] cmd_byte_ff, ram_data_ff;

  wire       in_ack    = (bcnt_ff == ACK_SLOT);
  wire       ent_ack   = scl_fall & (bcnt_ff == LAST_DBIT);
  wire       end_ack   = scl_fall & in_ack;
  wire       addr_hit  = (rx_ff[7:1] == {ADDR_HI, flt_ff[SY_SA1], flt_ff[SY_SA0]});
  wire       wr_state  = (st_ff == LDS_CTRL) | (st_ff == LDS_DATA);
  wire       nxt_ack   = ent_ack ? (((st_ff == LDS_ADDR) & addr_hit) | wr_state)
                                 : (end_ack ? 1'b0 : ack_ff);
  wire [2:0] tx_idx    = 3'(LAST_DBIT - bcnt_ff);
  wire       tx_drive  = (st_ff == LDS_READ) & ~dc_ff & ~in_ack & ~tx_ff[tx_idx];

  always_comb
  begin
    nxt_st = st_ff;
    if (end_ack)
    begin
      unique case (st_ff)
        LDS_ADDR: nxt_st = !addr_hit ? LDS_SKIP : (rw_ff ? LDS_READ : LDS_CTRL);
        LDS_CTRL: nxt_st = LDS_DATA;
        LDS_DATA: nxt_st = co_ff ? LDS_CTRL : LDS_DATA;
        LDS_READ: nxt_st = nack_ff ? LDS_SKIP : LDS_READ;
        LDS_IDLE: nxt_st = LDS_IDLE;
        LDS_SKIP: nxt_st = LDS_SKIP;
      endcase
    end
    if (stop_ev)
      nxt_st = LDS_IDLE;
    else if (start_ev)
      nxt_st = ready_ff ? LDS_ADDR : LDS_IDLE;
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      st_ff   <= LDS_IDLE;
      bcnt_ff <= 4'h0;
      ack_ff  <= 1'b0;
    end
    else
    begin
      st_ff   <= nxt_st;
      ack_ff  <= nxt_ack & ~(start_ev | stop_ev);
      // SCL fall that closes a START is not a data bit
      if (start_ev | stop_ev | lk_clr_ff)
        bcnt_ff <= 4'h0;
      else if (scl_fall)
        bcnt_ff <= in_ack ? 4'h0 : bcnt_ff + 4'h1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rx_ff       <= 8'h00;
      tx_ff       <= 8'h00;
      rw_ff       <= 1'b0;
      co_ff       <= 1'b0;
      dc_ff       <= 1'b0;
      nack_ff     <= 1'b1;
      cmd_ff      <= 1'b0;
      ram_ff      <= 1'b0;
      cmd_byte_ff <= 8'h00;
      ram_data_ff <= 8'h00;
    end
    else
    begin
      cmd_ff <= 1'b0;
      ram_ff <= 1'b0;
      if (byte_ev)
        rx_ff <= lk_byte_ff;
      if (ent_ack && st_ff == LDS_ADDR)
        rw_ff <= rx_ff[0];
      if (ent_ack && st_ff == LDS_CTRL)
      begin
        co_ff <= rx_ff[CO_BIT];
        dc_ff <= rx_ff[DC_BIT];
      end
      if (ent_ack && st_ff == LDS_DATA && !dc_ff)
      begin
        cmd_ff      <= 1'b1;
        cmd_byte_ff <= rx_ff;
      end
      if (ent_ack && st_ff == LDS_DATA && dc_ff)
      begin
        ram_ff      <= 1'b1;
        ram_data_ff <= rx_ff;
      end
      if (scl_rise && in_ack)
        nack_ff <= sda_h;
      if (end_ack && (nxt_st == LDS_READ))
        tx_ff <= i_temp_status;
    end
  end

  logic sdo_oe_b_ff;
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      sdo_oe_b_ff <= 1'b1;
    else
      sdo_oe_b_ff <= ~tx_drive | start_ev | stop_ev;
  end

  assign o_sda       = 1'b0;
  assign o_sda_oe_b  = ~ack_ff;
  assign o_sdo       = 1'b0;
  assign o_sdo_oe_b  = sdo_oe_b_ff;
  assign o_ready     = ready_ff;
  assign o_cmd_valid = cmd_ff;
  assign o_cmd_byte  = cmd_byte_ff;
  assign o_ram_wr    = ram_ff;
  assign o_ram_data  = ram_data_ff;
  assign o_dc_mode   = dc_ff;

  // Assertions
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  no_ack_miss_a: assert property (ent_ack && st_ff == LDS_ADDR && !addr_hit |=> !ack_ff)
    else $error("ack on mismatched address");
  addr_ack_a: assert property (ent_ack && st_ff == LDS_ADDR && addr_hit |=> ack_ff)
    else $error("matching address not acked");
  ack_hold_a: assert property (ack_ff && !scl_fall && !start_ev && !stop_ev |=> ack_ff)
    else $error("ack released early");
  ctrl_next_a: assert property (end_ack && st_ff == LDS_CTRL && !start_ev && !stop_ev
                                |=> st_ff == LDS_DATA)
    else $error("control byte not followed by data");
  co_one_a: assert property (end_ack && st_ff == LDS_DATA && co_ff && !start_ev && !stop_ev
                             |=> st_ff == LDS_CTRL)
    else $error("no new control byte after data");
  co_zero_a: assert property (end_ack && st_ff == LDS_DATA && !co_ff && !start_ev && !stop_ev
                              |=> st_ff == LDS_DATA)
    else $error("data stream broken");
  cmd_route_a: assert property (cmd_ff |-> !dc_ff && !ram_ff)
    else $error("command pulse with RAM mode");
  ram_route_a: assert property (ram_ff |-> dc_ff && o_ram_data == rx_ff)
    else $error("RAM write wrong");
  no_ram_read_a: assert property (dc_ff && st_ff == LDS_READ |=> o_sdo_oe_b)
    else $error("RAM read back driven");
  idle_rel_a: assert property (st_ff == LDS_IDLE |=> o_sdo_oe_b)
    else $error("data out driven when idle");
  route_rst_a: assert property (stop_ev |=> st_ff == LDS_IDLE)
    else $error("stop did not reset routing");
  ready_time_a: assert property ($rose(i_rst_b) |-> ##[1:300] ready_ff)
    else $error("not ready in 3 us");

  write_cv: cover property (ram_ff);
  cmd_cv: cover property (cmd_ff);
  read_cv: cover property (st_ff == LDS_READ && !o_sdo_oe_b);

endmodule : lds_i2c_slave
`default_nettype wire

// ==== tb/lds_master.sv ====
`timescale 1ns/1ps
`default_nettype none
module lds_master
(
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_pull
);
  // Quarter bit; SCL low and high each last two quarters
  localparam int Q = 64;
  initial
  begin
    o_scl  = 1'b1;
    o_pull = 1'b0;
  end
  task automatic start;
    o_pull = 1'b0;
    #Q o_scl = 1'b1;
    #Q o_pull = 1'b1;
    #Q o_scl = 1'b0;
    #Q;
  endtask : start
  task automatic stop;
    o_pull = 1'b1;
    #Q o_scl = 1'b1;
    #Q o_pull = 1'b0;
    #(4 * Q);
  endtask : stop
  // Data changes only while SCL is low
  task automatic bit_io(input logic b, output logic r);
    o_pull = !b;
    #Q o_scl = 1'b1;
    #Q r = i_sda;
    #Q o_scl = 1'b0;
    #Q;
  endtask : bit_io
  task automatic wr_byte(input logic [7:0] d, output logic nack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, nack);
  endtask : wr_byte
  task automatic rd_byte(output logic [7:0] d, input logic last);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask : rd_byte
endmodule : lds_master
`default_nettype wire

// ==== tb/tb_lds_i2c_slave.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_lds_i2c_slave;
  import lds_pkg::*;
  logic       i_clk = 1'b0;
  logic       i_rst_b = 1'b0;
  logic       sel0 = 1'b0;
  logic       sel1 = 1'b0;
  logic [7:0] temp = 8'h00;
  logic       scl, pull, sda_o, sda_oe_b, sdo, sdo_oe_b;
  logic       ready, cmd_v, ram_wr, dc;
  logic [7:0] cmd_b, ram_d, d, x;
  logic       nack;
  logic [7:0] ram_q[$], cmd_q[$], exp_ram[$], exp_cmd[$];
  logic [31:0] rs = 32'h0000436F;
  int         n_mismatch = 0;
  int         samples_checked = 0;
  int         cyc = 0;
  // Bus line with pull-up; serial_data_out is tied to it for read-back
  wire sda_line = !pull & (sda_oe_b | sda_o) & (sdo_oe_b | sdo);
  lds_master i_lds_master (.i_sda(sda_line), .o_scl(scl), .o_pull(pull));
  lds_i2c_slave i_lds_i2c_slave (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_scl(scl), .i_sda(sda_line),
    .o_sda(sda_o), .o_sda_oe_b(sda_oe_b), .o_sdo(sdo), .o_sdo_oe_b(sdo_oe_b),
    .i_addr_sel0(sel0), .i_addr_sel1(sel1), .i_temp_status(temp),
    .o_ready(ready), .o_cmd_valid(cmd_v), .o_cmd_byte(cmd_b),
    .o_ram_wr(ram_wr), .o_ram_data(ram_d), .o_dc_mode(dc));
  always #5 i_clk = ~i_clk;
  always @(posedge i_clk)
  begin
    if (ram_wr === 1'b1) ram_q.push_back(ram_d);
    if (cmd_v === 1'b1) cmd_q.push_back(cmd_b);
    cyc++;
    if (cyc == 80000)
    begin
      n_mismatch++;
      stop_test();
    end
  end
  function automatic logic [7:0] adr(input logic [1:0] s, input logic rw);
    return {5'h0F, s, rw};
  endfunction : adr
  function automatic logic [7:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs[7:0];
  endfunction : rnd
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test;
    if (n_mismatch == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  task automatic wr(input logic [7:0] b, input logic ram, input logic cmd);
    i_lds_master.wr_byte(b, nack);
    check({7'h00, nack}, 8'h00);
    if (ram) exp_ram.push_back(b);
    if (cmd) exp_cmd.push_back(b);
  endtask : wr
  task automatic ctrl_go(input logic rw);
    i_lds_master.start();
    wr(adr({sel1, sel0}, rw), 1'b0, 1'b0);
  endtask : ctrl_go
  initial
  begin
    @(posedge i_clk) #1;
    check({5'h00, ready, sda_oe_b, sdo_oe_b}, 8'h03);
    @(posedge i_clk) #1 i_rst_b = 1'b1;
    repeat (290) @(posedge i_clk);
    #1 check({7'h00, ready}, 8'h00);
    repeat (20) @(posedge i_clk);
    #1 check({7'h00, ready}, 8'h01);
    // Every select setting against every low address pair and one foreign address; junk bytes follow each miss
    for (int k = 0; k < 4; k++)
    begin
      @(posedge i_clk) #1 {sel1, sel0} = 2'(k);
      repeat (10) @(posedge i_clk);
      for (int j = 0; j < 5; j++)
      begin
        i_lds_master.start();
        i_lds_master.wr_byte((j == 4) ? 8'h38 : adr(2'(j), 1'b0), nack);
        check({7'h00, nack}, {7'h00, j != k});
        if (j != k) i_lds_master.wr_byte(8'h40, nack);
        if (j != k) i_lds_master.wr_byte(8'h5A, nack);
        i_lds_master.stop();
      end
    end
    // Data stream after a final control byte goes to RAM
    ctrl_go(1'b0);
    wr(8'h40, 1'b0, 1'b0);
    for (int i = 0; i < 5; i++)
    begin
      x = rnd();
      wr(x, 1'b1, 1'b0);
    end
    i_lds_master.stop();
    check({7'h00, dc}, 8'h01);
    // Alternating control and data, then a repeated start mid-stream
    ctrl_go(1'b0);
    for (int i = 0; i < 4; i++)
    begin
      x = rnd();
      wr({1'b1, x[0], 6'h00}, 1'b0, 1'b0);
      d = rnd();
      wr(d, x[0], !x[0]);
    end
    wr(8'h00, 1'b0, 1'b0);
    for (int i = 0; i < 3; i++)
    begin
      x = rnd();
      wr(x, 1'b0, 1'b1);
    end
    ctrl_go(1'b0);
    wr(8'hC0, 1'b0, 1'b0);
    x = rnd();
    wr(x, 1'b1, 1'b0);
    i_lds_master.stop();
    check(8'(ram_q.size()), 8'(exp_ram.size()));
    foreach (exp_ram[i]) check(ram_q[i], exp_ram[i]);
    check(8'(cmd_q.size()), 8'(exp_cmd.size()));
    foreach (exp_cmd[i]) check(cmd_q[i], exp_cmd[i]);
    // Read while RAM is selected returns nothing
    ctrl_go(1'b1);
    i_lds_master.rd_byte(d, 1'b1);
    check(d, 8'hFF);
    i_lds_master.stop();
    // Status read until the master refuses
    ctrl_go(1'b0);
    wr(8'h00, 1'b0, 1'b0);
    i_lds_master.stop();
    @(posedge i_clk) #1 temp = rnd();
    ctrl_go(1'b1);
    for (int i = 0; i < 3; i++)
    begin
      i_lds_master.rd_byte(d, i == 2);
      check(d, temp);
    end
    i_lds_master.stop();
    check({7'h00, sda_line}, 8'h01);
    stop_test();
  end
endmodule : tb_lds_i2c_slave
`default_nettype wire
